// ---- hdl/hods_pkg.sv ----
// constants and types shared by the hall output dsp chain
package hods_pkg;
  localparam int DATA_W = 12;
  localparam int SEG_N = 32;
  localparam int BRK_N = 33;
  localparam logic [11:0] FULL_SCALE = 12'hFFF;
  localparam logic [11:0] CLAMP_LO_RST = 12'h000;
  localparam logic [11:0] CLAMP_HI_RST = 12'hFFF;
  localparam logic [11:0] SAT_LOW_LEVEL = 12'h000;
  localparam logic [11:0] SAT_HIGH_LEVEL = 12'hFFF;
  localparam logic [11:0] HALF_SCALE = 12'h800;
  localparam logic [1:0] STAT_LOW_SUPPLY = 2'h1;
  localparam logic [1:0] STAT_OVERVOLT = 2'h2;
  localparam logic [1:0] STAT_NONE = 2'h0;
  localparam int FRAC_W = 11;
  typedef enum logic {HODS_FMT_SENT, HODS_FMT_PWM} hods_fmt_t;
  typedef enum logic [1:0] {HODS_ST_RESET, HODS_ST_NORMAL, HODS_ST_LOWSUP, HODS_ST_OVER} hods_state_t;
endpackage

// ---- hdl/hods_sat.sv ----
// signed saturation of a wide value into a signed 12-bit range
`timescale 1ns/1ps
`default_nettype none
module hods_sat (
  input wire logic signed [31:0] din,
  output logic signed [11:0] dout
);
  always_comb begin
    if (din > 32'sd2047) begin
      dout = 12'sh7FF;
    end else if (din < -32'sd2048) begin
      dout = 12'sh800;
    end else begin
      dout = din[11:0];
    end
  end
endmodule
`default_nettype wire

// ---- hdl/hods_lin.sv ----
// 32-segment piecewise linear interpolation over 33 breakpoints
`timescale 1ns/1ps
`default_nettype none
module hods_lin (
  input wire logic [11:0] din,
  input wire logic [33*12-1:0] brk_flat,
  output logic [11:0] dout
);
  logic signed [11:0] brk [0:32];
  genvar gi;
  generate
    for (gi = 0; gi < 33; gi = gi + 1) begin : g_brk
      assign brk[gi] = brk_flat[gi*12 +: 12];
    end
  endgenerate
  logic [4:0] seg;
  logic [6:0] frac;
  logic signed [12:0] d_lo;
  logic signed [12:0] d_hi;
  logic signed [20:0] prod;
  logic signed [13:0] y;
  always_comb begin
    seg = din[11:7];
    frac = din[6:0];
    d_lo = 13'(brk[seg]);
    d_hi = 13'(brk[5'(seg + 5'h1)]);
    if (seg == 5'h1F) begin
      d_hi = 13'(brk[32]);
    end
    prod = 21'(d_hi - d_lo) * $signed({14'h0, frac});
    y = 14'(d_lo) + 14'(prod >>> 7);
    if (y > 14'sd2047) begin
      y = 14'sd2047;
    end else if (y < -14'sd2048) begin
      y = -14'sd2048;
    end
    dout = y[11:0] ^ hods_pkg::HALF_SCALE; // back to offset binary
  end
endmodule
`default_nettype wire

// ---- hdl/hods_chain.sv ----
// hall output dsp chain: compensation, trim, linearization, clamps, supply faults
`timescale 1ns/1ps
`default_nettype none
module hods_chain (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] sample_in,
  input wire logic sample_valid,
  input wire logic signed [7:0] temp_delta,
  input wire logic signed [11:0] hot_first_order_coef,
  input wire logic signed [11:0] cold_first_order_coef,
  input wire logic signed [11:0] hot_second_order_coef,
  input wire logic signed [11:0] cold_second_order_coef,
  input wire logic signed [11:0] offset_drift_coef,
  input wire logic [11:0] fine_gain_code,
  input wire logic signed [11:0] fine_offset_code,
  input wire logic [33*12-1:0] lin_coef_flat,
  input wire logic lin_input_invert,
  input wire logic output_invert,
  input wire logic [11:0] clamp_low,
  input wire logic [11:0] clamp_high,
  input wire logic pwm_mode,
  input wire logic por_low,
  input wire logic low_supply_detect_in,
  input wire logic low_supply_high_in,
  input wire logic low_supply_detect_off,
  input wire logic overvolt_threshold_select,
  input wire logic overvolt_lo_in,
  input wire logic overvolt_hi_in,
  output logic [11:0] out_value,
  output logic out_valid,
  output logic out_pwm_sel,
  output logic [1:0] sent_status,
  output logic out_oe_n
);
  typedef struct packed {
    logic [2:0] por_sy;
    logic [2:0] lvd_sy;
    logic [2:0] lvh_sy;
    logic [2:0] ovl_sy;
    logic [2:0] ovh_sy;
    logic [11:0] tc_reg;
    logic [11:0] trim_reg;
    logic [2:0] vld;
    logic [11:0] out_value;
    logic out_valid;
    logic out_pwm_sel;
    logic [1:0] sent_status;
    logic out_oe_n;
    hods_pkg::hods_state_t st;
  } hods_state_s_t;
  hods_state_s_t s_reg, s_next;
  // synchroniser stage 0 feeds only stage 1; logic reads stage 1 as the live level
  logic por_s, lvd_s, lvh_s, ov_s;
  assign por_s = s_reg.por_sy[1];
  assign lvd_s = s_reg.lvd_sy[1];
  assign lvh_s = s_reg.lvh_sy[1];
  // one bit picks which comparator marks overvoltage
  assign ov_s = overvolt_threshold_select ? s_reg.ovl_sy[1] : s_reg.ovh_sy[1];
  logic signed [11:0] c1, c2;
  logic signed [12:0] xs;
  logic signed [15:0] dt2;
  logic signed [31:0] k, tc_wide, gain_wide, trim_wide;
  logic signed [12:0] gfac;
  logic signed [11:0] tc_sat, trim_sat;
  logic [11:0] lin_in, lin_out, pol, clamped;
  always_comb begin
    c1 = (temp_delta < 0) ? cold_first_order_coef : hot_first_order_coef;
    c2 = (temp_delta < 0) ? cold_second_order_coef : hot_second_order_coef;
    xs = 13'($signed({1'b0, sample_in}) - 13'sd2048);
    dt2 = 16'(temp_delta) * 16'(temp_delta);
    // first and second order coefficients scale in units of 2^-20 per degree and per degree squared to keep products small
    k = 32'(c1) * 32'(temp_delta) + 32'(c2) * 32'(dt2);
    tc_wide = 32'(xs) + ((32'(xs) * k) >>> 20) + 32'(offset_drift_coef) * 32'(temp_delta);
  end
  hods_sat u_sat_tc (.din(tc_wide), .dout(tc_sat));
  always_comb begin
    // code 0 -> 2048/2048, 2047 -> ~4095/2048, 2048 -> 0, 4095 -> ~1
    gfac = fine_gain_code[11] ? 13'({2'b00, fine_gain_code[10:0]})
                              : 13'({2'b00, fine_gain_code[10:0]} + 13'sd2048);
    gain_wide = (32'($signed(s_reg.tc_reg)) * 32'(gfac)) >>> hods_pkg::FRAC_W;
    // fine offset in 12-bit lsb of full scale; 2047 lsb is half scale
    trim_wide = gain_wide + 32'(fine_offset_code);
  end
  hods_sat u_sat_trim (.din(trim_wide), .dout(trim_sat));
  always_comb begin
    lin_in = s_reg.trim_reg;
    if (lin_input_invert) begin
      lin_in = ~s_reg.trim_reg;
    end
    lin_in = lin_in ^ hods_pkg::HALF_SCALE;
  end
  hods_lin u_lin (.din(lin_in), .brk_flat(lin_coef_flat), .dout(lin_out));
  always_comb begin
    pol = output_invert ? (hods_pkg::FULL_SCALE - lin_out) : lin_out;
    if (pol < clamp_low) begin
      clamped = clamp_low;
    end else if (pol > clamp_high) begin
      clamped = clamp_high;
    end else begin
      clamped = pol;
    end
  end
  always_comb begin
    s_next = s_reg;
    s_next.por_sy = {s_reg.por_sy[1:0], por_low};
    s_next.lvd_sy = {s_reg.lvd_sy[1:0], low_supply_detect_in};
    s_next.lvh_sy = {s_reg.lvh_sy[1:0], low_supply_high_in};
    s_next.ovl_sy = {s_reg.ovl_sy[1:0], overvolt_lo_in};
    s_next.ovh_sy = {s_reg.ovh_sy[1:0], overvolt_hi_in};
    s_next.vld = {s_reg.vld[1:0], sample_valid};
    if (sample_valid) begin
      s_next.tc_reg = tc_sat;
    end
    if (s_reg.vld[0]) begin
      s_next.trim_reg = trim_sat;
    end
    s_next.out_pwm_sel = pwm_mode;
    s_next.out_valid = 1'b0;
    case (s_reg.st)
      hods_pkg::HODS_ST_RESET: begin
        if (!por_s) begin
          s_next.st = hods_pkg::HODS_ST_NORMAL;
        end
      end
      hods_pkg::HODS_ST_NORMAL: begin
        if (ov_s) begin
          s_next.st = hods_pkg::HODS_ST_OVER;
        end else if (lvd_s && !low_supply_detect_off) begin
          s_next.st = hods_pkg::HODS_ST_LOWSUP;
        end
      end
      hods_pkg::HODS_ST_LOWSUP: begin
        if (ov_s) begin
          s_next.st = hods_pkg::HODS_ST_OVER;
        end else if (low_supply_detect_off || lvh_s) begin
          s_next.st = hods_pkg::HODS_ST_NORMAL;
        end
      end
      hods_pkg::HODS_ST_OVER: begin
        // lockout lasts only while the comparator holds; pulses may toggle it
        // a supply still low when the lockout lifts goes straight to its own fault state
        if (!ov_s && lvd_s && !low_supply_detect_off) begin
          s_next.st = hods_pkg::HODS_ST_LOWSUP;
        end else if (!ov_s) begin
          s_next.st = hods_pkg::HODS_ST_NORMAL;
        end
      end
      default: begin
        s_next.st = hods_pkg::HODS_ST_RESET;
      end
    endcase
    if (por_s) begin
      s_next.st = hods_pkg::HODS_ST_RESET;
    end
    s_next.out_oe_n = (s_next.st == hods_pkg::HODS_ST_RESET);
    s_next.sent_status = hods_pkg::STAT_NONE;
    case (s_next.st)
      hods_pkg::HODS_ST_RESET: begin
        s_next.out_value = hods_pkg::SAT_LOW_LEVEL;
      end
      hods_pkg::HODS_ST_LOWSUP: begin
        if (pwm_mode) begin
          s_next.out_value = hods_pkg::SAT_LOW_LEVEL;
        end else begin
          s_next.sent_status = hods_pkg::STAT_LOW_SUPPLY;
          if (s_reg.vld[1]) begin
            s_next.out_value = clamped;
          end
        end
      end
      hods_pkg::HODS_ST_OVER: begin
        if (pwm_mode) begin
          s_next.out_value = hods_pkg::SAT_HIGH_LEVEL;
        end else begin
          s_next.sent_status = hods_pkg::STAT_OVERVOLT;
          if (s_reg.vld[1]) begin
            s_next.out_value = clamped;
          end
        end
      end
      default: begin
        if (s_reg.vld[1]) begin
          s_next.out_value = clamped;
          s_next.out_valid = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{por_sy: 3'h7, lvd_sy: 3'h0, lvh_sy: 3'h0, ovl_sy: 3'h0, ovh_sy: 3'h0,
                 tc_reg: 12'h000, trim_reg: 12'h000, vld: 3'h0,
                 out_value: hods_pkg::SAT_LOW_LEVEL, out_valid: 1'b0, out_pwm_sel: 1'b0,
                 sent_status: hods_pkg::STAT_NONE, out_oe_n: 1'b1,
                 st: hods_pkg::HODS_ST_RESET};
    end else begin
      s_reg <= s_next;
    end
  end
  assign out_value = s_reg.out_value;
  assign out_valid = s_reg.out_valid;
  assign out_pwm_sel = s_reg.out_pwm_sel;
  assign sent_status = s_reg.sent_status;
  assign out_oe_n = s_reg.out_oe_n;
endmodule
`default_nettype wire

// ---- dv/hods_ecu_model.sv ----
// controller model that keeps the last trusted output code
`timescale 1ns/1ps
`default_nettype none
module hods_ecu_model (
  input wire logic mclk,
  input wire logic out_valid,
  input wire logic [11:0] out_value,
  input wire logic [1:0] sent_status,
  input wire logic out_oe_n,
  output logic [11:0] seen_value
);
  // codes under a fault flag or a floating pin are not trusted
  always @(posedge mclk) begin
    if (out_valid && !out_oe_n && sent_status == 2'h0) begin
      seen_value <= out_value;
    end
  end
endmodule
`default_nettype wire

// ---- dv/hods_chain_properties.sv ----
// assertions on the hall output dsp chain ports
`timescale 1ns/1ps
`default_nettype none
module hods_chain_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sample_valid,
  input wire logic [11:0] clamp_low,
  input wire logic [11:0] clamp_high,
  input wire logic pwm_mode,
  input wire logic por_low,
  input wire logic low_supply_detect_in,
  input wire logic low_supply_detect_off,
  input wire logic overvolt_threshold_select,
  input wire logic overvolt_lo_in,
  input wire logic overvolt_hi_in,
  input wire logic [11:0] out_value,
  input wire logic out_valid,
  input wire logic [1:0] sent_status,
  input wire logic out_oe_n
);
  wire ov = overvolt_threshold_select ? overvolt_lo_in : overvolt_hi_in;
  wire ls = low_supply_detect_in && !low_supply_detect_off && !ov && !por_low;
  wire calm = !por_low && !low_supply_detect_in && !ov && !out_oe_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // fault levels pass a two-flop sync, so they must stand four edges
  sequence s_held(x); x [*4]; endsequence
  sequence s_take; calm && sent_status == hods_pkg::STAT_NONE && sample_valid; endsequence
  a_valid_latency: assert property (s_take |-> ##3 out_valid)
    else $error("result pulse missing");
  a_valid_cause: assert property (out_valid |-> $past(sample_valid, 3))
    else $error("result pulse without sample");
  a_pwm_lowsup: assert property (s_held(pwm_mode && ls) |->
    out_value == hods_pkg::SAT_LOW_LEVEL) else $error("pwm low supply level wrong");
  a_pwm_overvolt: assert property (s_held(pwm_mode && ov && !por_low) |->
    out_value == hods_pkg::SAT_HIGH_LEVEL) else $error("pwm overvolt level wrong");
  a_sent_lowsup: assert property (s_held(!pwm_mode && ls) |->
    sent_status == hods_pkg::STAT_LOW_SUPPLY) else $error("low supply flag wrong");
  a_sent_overvolt: assert property (s_held(!pwm_mode && ov && !por_low) |->
    sent_status == hods_pkg::STAT_OVERVOLT) else $error("overvolt flag wrong");
  a_detect_off: assert property (s_held(!pwm_mode && low_supply_detect_off && !ov && !por_low) |->
    sent_status == hods_pkg::STAT_NONE) else $error("disabled detect flagged");
  a_por_hiz: assert property (s_held(por_low) |-> out_oe_n && !out_valid)
    else $error("output driven in power-on reset");
  a_fault_quiet: assert property (out_valid |-> !out_oe_n && sent_status == 2'h0)
    else $error("result pulse during fault");
  a_clamp_window: assert property (out_valid && clamp_low <= clamp_high |->
    out_value >= clamp_low && out_value <= clamp_high) else $error("output outside clamps");
endmodule
bind hods_chain hods_chain_properties u_props (.*);
`default_nettype wire

// ---- dv/hods_chain_tb.sv ----
// self-checking bench for the hall output dsp chain
`timescale 1ns/1ps
`default_nettype none
module hods_chain_tb;
  typedef struct packed {
    logic [11:0] smp;
    logic [11:0] off;
    logic [7:0] td;
    logic [11:0] lo;
    logic [11:0] hi;
    logic [2:0] iop;
    logic [11:0] exp;
  } hods_row_t;
  // iop: lin invert, out invert, pwm; identity breakpoints make expectations direct
  hods_row_t rows [10] = '{
    '{12'h400, 12'h000, 8'h00, 12'h000, 12'hFFF, 3'h0, 12'h400},
    '{12'h400, 12'h000, 8'h00, 12'h000, 12'hFFF, 3'h3, 12'hBFF},
    '{12'h400, 12'h000, 8'h00, 12'h000, 12'hFFF, 3'h4, 12'hBFF},
    '{12'h400, 12'h100, 8'h00, 12'h000, 12'hFFF, 3'h0, 12'h500},
    '{12'h400, 12'hF00, 8'h00, 12'h000, 12'hFFF, 3'h0, 12'h300},
    '{12'h100, 12'h800, 8'h00, 12'h000, 12'hFFF, 3'h0, 12'h000},
    '{12'h400, 12'h000, 8'h02, 12'h000, 12'hFFF, 3'h0, 12'h420},
    '{12'h400, 12'h000, 8'hFE, 12'h000, 12'hFFF, 3'h0, 12'h3E0},
    '{12'h300, 12'h000, 8'h00, 12'h500, 12'hFFF, 3'h0, 12'h500},
    '{12'hD00, 12'h000, 8'h00, 12'h500, 12'hC00, 3'h0, 12'hC00}};
  logic mclk = 0;
  logic rst_n = 0;
  logic [11:0] sample_in = 0;
  logic sample_valid = 0;
  logic signed [7:0] temp_delta = 0;
  logic signed [11:0] fine_offset_code = 0;
  logic signed [11:0] drift = 12'h010;
  logic [395:0] lin_coef_flat = 0;
  logic lin_input_invert = 0;
  logic output_invert = 0;
  logic [11:0] clamp_low = 0;
  logic [11:0] clamp_high = 12'hFFF;
  logic pwm_mode = 0;
  logic por_low = 0;
  logic [5:0] flags = 0;
  logic [11:0] out_value;
  logic [11:0] seen_value;
  logic out_valid;
  logic out_pwm_sel;
  logic out_oe_n;
  logic [1:0] sent_status;
  int miscompares = 0;
  int check_count = 0;
  always #20 mclk = ~mclk;
  hods_chain DUT (
    .mclk(mclk), .rst_n(rst_n), .sample_in(sample_in), .sample_valid(sample_valid),
    .temp_delta(temp_delta), .hot_first_order_coef(12'h000), .cold_first_order_coef(12'h000),
    .hot_second_order_coef(12'h000), .cold_second_order_coef(12'h000),
    .offset_drift_coef(drift), .fine_gain_code(12'h000), .fine_offset_code(fine_offset_code),
    .lin_coef_flat(lin_coef_flat), .lin_input_invert(lin_input_invert),
    .output_invert(output_invert), .clamp_low(clamp_low), .clamp_high(clamp_high),
    .pwm_mode(pwm_mode), .por_low(por_low), .low_supply_detect_in(flags[5]),
    .low_supply_high_in(flags[4]), .low_supply_detect_off(flags[3]),
    .overvolt_threshold_select(flags[2]), .overvolt_lo_in(flags[1]), .overvolt_hi_in(flags[0]),
    .out_value(out_value), .out_valid(out_valid), .out_pwm_sel(out_pwm_sel),
    .sent_status(sent_status), .out_oe_n(out_oe_n));
  hods_ecu_model u_ecu (.mclk(mclk), .out_valid(out_valid), .out_value(out_value),
    .sent_status(sent_status), .out_oe_n(out_oe_n), .seen_value(seen_value));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic run(input hods_row_t r);
    @(posedge mclk);
    #1;
    {sample_in, fine_offset_code, temp_delta} = {r.smp, r.off, r.td};
    {clamp_low, clamp_high} = {r.lo, r.hi};
    {lin_input_invert, output_invert, pwm_mode} = r.iop;
    sample_valid = 1;
    @(posedge mclk);
    #1;
    sample_valid = 0;
    // result pulse stands for the one cycle after the third edge from the take
    repeat (2) @(posedge mclk);
    #1;
    chk({11'h0, out_valid}, 12'h001);
    chk(out_value, r.exp);
    chk({11'h0, out_pwm_sel}, {11'h0, r.iop[0]});
    @(posedge mclk);
    #1;
    chk(seen_value, r.exp);
  endtask
  // faults are judged five edges on, past the input sync
  task automatic flt(input logic p, input logic [5:0] f, input logic [11:0] e);
    pwm_mode = p;
    flags = f;
    repeat (5) @(posedge mclk);
    #1;
    chk(p ? out_value : {10'h0, sent_status}, e);
  endtask
  initial begin
    for (int i = 0; i < 33; i++) begin
      lin_coef_flat[12*i +: 12] = (i == 32) ? 12'h7FF : 12'(128 * i - 2048);
    end
    repeat (4) @(posedge mclk);
    #1;
    chk({11'h0, out_oe_n}, 12'h001);
    rst_n = 1;
    repeat (6) @(posedge mclk);
    #1;
    chk({11'h0, out_oe_n}, 12'h000);
    foreach (rows[i]) run(rows[i]);
    flt(1, 6'h20, 12'h000);
    flags = 6'h10;
    repeat (4) @(posedge mclk);
    run(rows[9]);
    flt(1, 6'h06, 12'hFFF);
    flt(0, 6'h02, 12'h000);
    flt(0, 6'h01, 12'h002);
    flt(0, 6'h20, 12'h001);
    flt(0, 6'h28, 12'h000);
    flags = 6'h00;
    por_low = 1;
    repeat (5) @(posedge mclk);
    #1;
    chk({11'h0, out_oe_n}, 12'h001);
    por_low = 0;
    repeat (6) @(posedge mclk);
    run(rows[0]);
    print_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
